//--- lfb_led_ctrl.sv
// LED sink controller: register slave, fade ramps, blink timers, boost control
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module lfb_led_ctrl
  import lfb_pkg::*;
#(
  parameter int unsigned STEP_UNIT_CYCLES  = STEP_UNIT_DEF,
  parameter int unsigned BLINK_UNIT_CYCLES = BLINK_UNIT_DEF
) (
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic [ADDR_W-1:0]              avs_address_i,
  input  wire logic                           avs_read_i,
  input  wire logic                           avs_write_i,
  input  wire logic [31:0]                    avs_writedata_i,
  input  wire logic [3:0]                     avs_byteenable_i,
  output logic      [31:0]                    avs_readdata_o,
  output logic                                avs_waitrequest_o,
  output logic [NUM_CH-1:0][LVL_W-1:0]        sink_code_o,
  output logic [NUM_CH-1:0][UA_W-1:0]         sink_ua_o,
  output logic                                boost_led_mode_o,
  output logic                                boost_active_o,
  output logic                                ovp_low_o
);

  if (STEP_UNIT_CYCLES < 1 || BLINK_UNIT_CYCLES < 1) begin : g_chk
    $error("Step and blink units must be at least one cycle");
  end

  lfb_ctrl_s                    ctrl;
  lfb_group_s                   grp;
  lfb_fade_s                    fade;
  logic [3:0]                   chan_on;
  logic [3:0][LVL_W-1:0]        sink_set;
  lfb_blink_s [NUM_BLK-1:0]     blink;
  logic                         ack;
  logic                         req;
  logic                         wr_fire;
  logic [31:0]                  wr_word;
  logic [31:0]                  rd_word;
  logic                         skip_q;
  logic                         led_mode;
  logic [NUM_CH-1:0][LVL_W-1:0] lvl;
  logic [NUM_CH-1:0][LVL_W-1:0] tgt;
  logic [NUM_CH-1:0]            fade_use;
  logic [NUM_CH-1:0]            jump;
  logic [NUM_CH-1:0]            blink_act;
  logic [NUM_CH-1:0]            lit;
  lfb_status_s                  status;

  // Bytes of old merged with write data under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // One wait state on every access; request completes when ack is high
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign wr_fire           = avs_write_i & ack;
  assign led_mode          = ~ctrl.boost_mode_select;  // see [R17]

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Current contents of the addressed register, before merge
  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address_i)
      OFS_CTRL:   rd_word = 32'(ctrl);
      OFS_GROUP:  rd_word = 32'(grp);
      OFS_FADE:   rd_word = 32'(fade);
      OFS_CHON:   rd_word = 32'(chan_on);
      OFS_STATUS: rd_word = 32'(status);
      default: begin
        if (avs_address_i[5:4] == PAGE_SINK) begin
          rd_word = 32'(sink_set[avs_address_i[3:2]]);
        end else if (avs_address_i[5:4] == PAGE_BLINK && avs_address_i[3:2] != 2'h3) begin
          rd_word = 32'(blink[avs_address_i[3:2]]);
        end
      end
    endcase
  end

  assign wr_word = be_merge(rd_word, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~ack) begin
      avs_readdata_o <= rd_word;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl     <= CTRL_RST;
      grp      <= GROUP_RST;
      fade     <= FADE_RST;
      chan_on  <= 4'h0;
      sink_set <= '0;
      blink    <= {NUM_BLK{BLINK_RST}};
    end else if (wr_fire) begin
      case (avs_address_i)
        OFS_CTRL:  ctrl    <= lfb_ctrl_s'(wr_word[$bits(lfb_ctrl_s)-1:0]);
        OFS_GROUP: begin
          grp      <= lfb_group_s'(wr_word[$bits(lfb_group_s)-1:0]);
          grp.rsvd <= 2'h0;
        end
        OFS_FADE:  fade    <= lfb_fade_s'(wr_word[$bits(lfb_fade_s)-1:0]);
        OFS_CHON:  chan_on <= wr_word[3:0];
        default: begin
          if (avs_address_i[5:4] == PAGE_SINK) begin
            sink_set[avs_address_i[3:2]] <= wr_word[LVL_W-1:0];
          end else if (avs_address_i[5:4] == PAGE_BLINK && avs_address_i[3:2] != 2'h3) begin
            blink[avs_address_i[3:2]] <= lfb_blink_s'(wr_word[$bits(lfb_blink_s)-1:0]);
          end
        end
      endcase
    end
  end

  // Jump is applied a cycle later so it lands on the newly written target
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= wr_fire && avs_address_i == OFS_CTRL && avs_byteenable_i[0]
                && ctrl.fade_skip_enable && lvl[0] != tgt[0];  // see [R09]
    end
  end

  // Targets per channel; channel 0 is the backlight group
  always_comb begin
    tgt       = '0;
    fade_use  = '0;
    jump      = '0;
    tgt[0]      = (led_mode && ctrl.backlight_on) ? grp.backlight_level_code : '0;  // see [R03]
    fade_use[0] = 1'b1;  // see [R04]
    jump[0]     = skip_q | ~led_mode;  // see [R21]
    for (int c = 1; c < NUM_CH; c++) begin
      // Joined channel keeps its own ramp idle at zero
      jump[c]     = grp.channel_group_join[c-1] | ~led_mode;  // see [R10]
      fade_use[c] = blink_act[c];  // see [R15]
      if (led_mode && !grp.channel_group_join[c-1] && chan_on[c-1] && lit[c]) begin
        tgt[c] = sink_set[c-1];  // see [R11]
      end
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [31:0] cnt;
    logic [31:0] step_len;
    logic [3:0]  rcode;
    logic        up;
    assign up       = tgt[c] > lvl[c];
    assign rcode    = up ? fade.fade_in_rate : fade.fade_out_rate;  // see [R05]
    // Full 0..63 sweep takes the rate; partial moves scale by code
    assign step_len = 32'(lfb_rate_tenths(rcode)) * STEP_UNIT_CYCLES;  // see [R08]
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        lvl[c] <= '0;
        cnt    <= 32'h0000_0000;
      end else if (jump[c] || !fade_use[c] || rcode == RATE_OFF) begin  // see [R06]
        lvl[c] <= tgt[c];
        cnt    <= 32'h0000_0000;
      end else if (lvl[c] == tgt[c]) begin
        cnt    <= 32'h0000_0000;
      end else if (cnt >= step_len - 32'h1) begin
        cnt    <= 32'h0000_0000;
        lvl[c] <= up ? lvl[c] + 6'h01 : lvl[c] - 6'h01;  // see [R22]
      end else begin
        cnt    <= cnt + 32'h1;
      end
    end
    // Outputs cleared at once in standalone mode, ramps jump to zero on the same edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        sink_code_o[c] <= '0;
      end else if (!led_mode) begin
        sink_code_o[c] <= '0;  // see [R21]
      end else if (c != 0 && grp.channel_group_join[c == 0 ? 0 : c-1]) begin
        sink_code_o[c] <= lvl[0];  // see [R10]
      end else begin
        sink_code_o[c] <= lvl[c];  // see [R01]
      end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        sink_ua_o[c] <= '0;
      end else begin
        sink_ua_o[c] <= lfb_square_ua(sink_code_o[c]);  // see [R02]
      end
    end
  end

  // Channels without a blink timer are always in the lit phase
  for (genvar c = 0; c < NUM_CH; c++) begin : g_blk
    if (c >= BLK_FIRST) begin : g_on
      lfb_blk_e    st;
      logic [31:0] cnt;
      logic [31:0] on_len;
      logic [31:0] off_len;
      lfb_blink_s  b;
      assign b       = blink[c-BLK_FIRST];
      assign on_len  = 32'(b.blink_on_time == 4'h0 ? 4'h1 : b.blink_on_time) * BLINK_UNIT_CYCLES;
      assign off_len = 32'(b.blink_off_time) * BLINK_UNIT_CYCLES;
      assign blink_act[c] = led_mode && !grp.channel_group_join[c-1] && chan_on[c-1]
                            && b.blink_off_time != 4'h0;  // see [R13] see [R14]
      assign lit[c] = st != BLK_OFF;
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          st  <= BLK_IDLE;
          cnt <= 32'h0000_0000;
        end else if (!blink_act[c]) begin
          st  <= BLK_IDLE;
          cnt <= 32'h0000_0000;
        end else begin
          case (st)
            BLK_IDLE: begin
              // All channels enabled by one write leave idle on one edge
              st  <= BLK_ON;  // see [R16] see [R12]
              cnt <= 32'h0000_0000;
            end
            BLK_ON: begin
              cnt <= (cnt >= on_len - 32'h1) ? 32'h0000_0000 : cnt + 32'h1;
              if (cnt >= on_len - 32'h1) begin
                st <= BLK_OFF;
              end
            end
            BLK_OFF: begin
              cnt <= (cnt >= off_len - 32'h1) ? 32'h0000_0000 : cnt + 32'h1;
              if (cnt >= off_len - 32'h1) begin
                st <= BLK_ON;
              end
            end
            default: begin
              st  <= BLK_IDLE;
              cnt <= 32'h0000_0000;
            end
          endcase
        end
      end
    end else begin : g_none
      assign blink_act[c] = 1'b0;
      assign lit[c]       = 1'b1;
    end
  end

  // Boost demand: group always, independent sinks only when bias is shared
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      boost_active_o   <= 1'b0;
      boost_led_mode_o <= 1'b1;
      ovp_low_o        <= 1'b0;
    end else begin
      boost_led_mode_o <= led_mode;  // see [R17]
      ovp_low_o        <= ctrl.overvoltage_level;  // see [R19]
      boost_active_o   <= led_mode && (lvl[0] != '0 || (!ctrl.bias_source_select
                          && lvl[NUM_CH-1:1] != '0));  // see [R18]
    end
  end

  assign status.blink_lit    = {lit[4] & blink_act[4], lit[3] & blink_act[3],
                                lit[2] & blink_act[2]};
  assign status.led_mode     = led_mode;
  assign status.boost_active = boost_active_o;
  assign status.group_fading = lvl[0] != tgt[0];
  assign status.group_level  = lvl[0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  standalone_off_a: assert property (!led_mode |=> sink_code_o == '0)  // see [R21]
    else $error("Sinks not off in standalone mode");
  join_follow_a: assert property (led_mode && grp.channel_group_join[0]
    |=> sink_code_o[1] == $past(lvl[0]))  // see [R10]
    else $error("Joined channel does not follow group level");
  indep_code_a: assert property (!grp.channel_group_join[0] |=> lvl[1] == $past(tgt[1]))  // see [R11]
    else $error("Independent channel not at own target");
  fade_step_a: assert property (lvl[0] != $past(lvl[0]) && !$past(jump[0])
    && $past(g_ch[0].rcode) != RATE_OFF
    |-> (lvl[0] == $past(lvl[0]) + 6'h01 || lvl[0] == $past(lvl[0]) - 6'h01))  // see [R22]
    else $error("Fade moved more than one code");
  fade_off_a: assert property (g_ch[0].rcode == RATE_OFF |=> lvl[0] == $past(tgt[0]))  // see [R06]
    else $error("Disabled fade did not switch at once");
  skip_jump_a: assert property (skip_q |=> lvl[0] == $past(tgt[0]))  // see [R09]
    else $error("Fade skip did not jump to target");
  blink_ignore_a: assert property (grp.channel_group_join[1] |=> g_blk[2].g_on.st == BLK_IDLE)  // see [R14]
    else $error("Joined channel is blinking");
  blink_enter_a: assert property (blink_act[3] ##1 blink_act[3] |-> g_blk[3].g_on.st != BLK_IDLE)  // see [R13]
    else $error("Blink not entered");
  blink_sync_a: assert property ($rose(blink_act[3]) && $rose(blink_act[4])  // see [R16]
    |=> g_blk[3].g_on.cnt == g_blk[4].g_on.cnt && g_blk[3].g_on.st == g_blk[4].g_on.st)
    else $error("Blink channels started apart");
  square_law_a: assert property (##1 sink_ua_o[0] == lfb_square_ua($past(sink_code_o[0])))  // see [R02]
    else $error("Square law current mismatch");

  fade_done_c: cover property (lvl[0] == 6'h3F ##1 status.group_fading == 1'b0);
  skip_seen_c: cover property (skip_q);
  blink_off_c: cover property (g_blk[4].g_on.st == BLK_OFF);
  standalone_c: cover property ($fell(led_mode));

endmodule // lfb_led_ctrl

//--- lfb_pkg.sv
// Constants, types and register map of the LED fade and blink controller
// Function
// [R01] Six-bit group code selects 64 levels
// [R02] Code maps to current by square law
// [R03] backlight_on turns backlight on or off
// [R04] Turn on/off fades through level codes
// [R05] Separate fade-in and fade-out rates, 15 each
// [R06] Rate code zero disables fading
// [R07] Host writes fade rates before backlight_on
// [R08] Rate is full-scale time, scaled by code
// [R09] Fade skip: rewrite jumps to target
// [R10] Joined channel follows channel 1 controls
// [R11] Unjoined channel uses own code, enable
// [R12] Blink timers only on channels 3 to 5
// [R13] Nonzero off-time enters blink operation
// [R14] Blink ignored on joined channels
// [R15] Blink fades, but without fade skip
// [R16] Same-write enabled blinkers start together
// [R17] Boost mode zero is LED operation
// [R18] Bias select limits boost to group
// [R19] Overvoltage level one selects 5.6 V
// [R20] Host configures, then backlight, then indicators
// [R21] Standalone boost mode forces LEDs off
// [R22] Fade steps one code per rate/63
package lfb_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned TENTH_SEC_NS   = 100_000_000;
  localparam int unsigned LVL_STEPS      = 63;
  // Per tenth-second of rate, cycles of one code step, rounded down
  localparam int unsigned STEP_UNIT_DEF  = TENTH_SEC_NS / CLK_PERIOD_NS / LVL_STEPS;
  localparam int unsigned BLINK_UNIT_MS  = 100;
  localparam int unsigned BLINK_UNIT_DEF = BLINK_UNIT_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned FS_UA          = 20000;
  localparam int unsigned NUM_CH         = 5;
  localparam int unsigned NUM_BLK        = 3;
  localparam int unsigned BLK_FIRST      = 2;
  localparam int          LVL_W          = 6;
  localparam int          UA_W           = 15;
  localparam int          ADDR_W         = 6;
  localparam logic [5:0]  OFS_CTRL       = 6'h00;
  localparam logic [5:0]  OFS_GROUP      = 6'h04;
  localparam logic [5:0]  OFS_FADE       = 6'h08;
  localparam logic [5:0]  OFS_CHON       = 6'h0C;
  localparam logic [1:0]  PAGE_SINK      = 2'h1;
  localparam logic [1:0]  PAGE_BLINK     = 2'h2;
  localparam logic [5:0]  OFS_STATUS     = 6'h30;
  localparam logic [3:0]  RATE_OFF       = 4'h0;
  typedef struct packed {
    logic overvoltage_level;
    logic bias_source_select;
    logic boost_mode_select;
    logic fade_skip_enable;
    logic backlight_on;
  } lfb_ctrl_s;
  typedef struct packed {
    logic [3:0] channel_group_join;
    logic [1:0] rsvd;
    logic [5:0] backlight_level_code;
  } lfb_group_s;
  typedef struct packed {
    logic [3:0] fade_out_rate;
    logic [3:0] fade_in_rate;
  } lfb_fade_s;
  typedef struct packed {
    logic [3:0] blink_off_time;
    logic [3:0] blink_on_time;
  } lfb_blink_s;
  typedef struct packed {
    logic [2:0] blink_lit;
    logic       led_mode;
    logic       boost_active;
    logic       group_fading;
    logic [5:0] group_level;
  } lfb_status_s;
  typedef enum logic [1:0] {BLK_IDLE, BLK_ON, BLK_OFF} lfb_blk_e;
  localparam lfb_ctrl_s  CTRL_RST  = '0;
  localparam lfb_group_s GROUP_RST = '0;
  localparam lfb_fade_s  FADE_RST  = '0;
  localparam lfb_blink_s BLINK_RST = '0;

  // Full-scale fade time in tenths of a second
  function automatic logic [5:0] lfb_rate_tenths(input logic [3:0] c);
    case (c)
      4'h1:    return 6'd3;
      4'h2:    return 6'd6;
      4'h3:    return 6'd9;
      4'h4:    return 6'd12;
      4'h5:    return 6'd9;
      4'h6:    return 6'd12;
      4'h7:    return 6'd21;
      4'h8:    return 6'd24;
      4'h9:    return 6'd27;
      4'hA:    return 6'd30;
      4'hB:    return 6'd33;
      4'hC:    return 6'd36;
      4'hD:    return 6'd39;
      4'hE:    return 6'd42;
      4'hF:    return 6'd45;
      default: return 6'd0;
    endcase
  endfunction

  // Sink current in microamps for a level code
  function automatic logic [14:0] lfb_square_ua(input logic [5:0] code);
    logic [31:0] p;
    p = 32'(code) * 32'(code) * FS_UA / (LVL_STEPS * LVL_STEPS);
    return p[14:0];
  endfunction
endpackage

//--- lfb_led_load.sv
// Behavioural LED string load seen at the sink outputs
`timescale 1ns/100ps
module lfb_led_load
  import lfb_pkg::*;
(
  input  wire logic [NUM_CH-1:0][UA_W-1:0] sink_ua_i,
  input  wire logic                        led_mode_i,
  output logic      [NUM_CH-1:0]           lit_o,
  output logic      [19:0]                 total_ua_o
);
  // A string conducts only while the boost serves LEDs and its sink pulls current
  always_comb begin
    total_ua_o = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      lit_o[i]   = led_mode_i && (sink_ua_i[i] != '0);
      total_ua_o = total_ua_o + (lit_o[i] ? 20'(sink_ua_i[i]) : 20'h0);
    end
  end
endmodule // lfb_led_load

//--- tb.sv
// Self-checking bench for the LED fade and blink controller
`timescale 1ns/100ps
module tb;
  import lfb_pkg::*;
  localparam int STEP = 2;
  localparam int BLU  = 4;
  logic                         clk_i = 1'b0;
  logic                         sys_rst_i = 1'b1;
  logic                         avs_read_i = 1'b0;
  logic                         avs_write_i = 1'b0;
  logic [ADDR_W-1:0]            avs_address_i = '0;
  logic [31:0]                  avs_writedata_i = '0;
  logic [3:0]                   avs_byteenable_i = 4'hF;
  logic [31:0]                  avs_readdata_o;
  logic [31:0]                  q;
  logic                         avs_waitrequest_o;
  logic                         boost_led_mode_o;
  logic                         boost_active_o;
  logic                         ovp_low_o;
  logic [NUM_CH-1:0][LVL_W-1:0] sink_code_o;
  logic [NUM_CH-1:0][UA_W-1:0]  sink_ua_o;
  logic [NUM_CH-1:0]            lit;
  logic [19:0]                  total_ua;
  int                           fail_count = 0;
  int                           num_checks = 0;
  int                           n;
  int                           c;
  int                           fi;
  int                           fo;
  int                           exp_n;
  int                           ref_q[$];

  always #20 clk_i = ~clk_i;

  lfb_led_ctrl #(.STEP_UNIT_CYCLES(STEP), .BLINK_UNIT_CYCLES(BLU)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sink_code_o(sink_code_o), .sink_ua_o(sink_ua_o),
    .boost_led_mode_o(boost_led_mode_o), .boost_active_o(boost_active_o),
    .ovp_low_o(ovp_low_o));

  lfb_led_load u_load (.sink_ua_i(sink_ua_o), .led_mode_i(boost_led_mode_o),
    .lit_o(lit), .total_ua_o(total_ua));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge; data taken there
  task automatic bus(input bit wr, input int a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i   <= 6'(a);
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    chk(k < 20, "bus answer missing");
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  function automatic int sq_ua(input int code);
    return code * code * 20000 / 3969;
  endfunction

  // Unlisted codes 5 and 6 repeat the 0.9 s and 1.2 s rates
  function automatic int tenths(input int code);
    return (code == 5 || code == 6) ? 3 * (code - 2) : 3 * code;
  endfunction

  task automatic wait_code(input int ch, input int v, input bit stp, output int cyc);
    int prev;
    cyc  = 0;
    prev = int'(sink_code_o[ch]);
    while (sink_code_o[ch] !== 6'(v) && cyc < 3000) begin
      @(negedge clk_i);
      if (stp && int'(sink_code_o[ch]) != prev)
        chk((int'(sink_code_o[ch]) - prev) ** 2 == 1, "fade skipped a code");
      prev = int'(sink_code_o[ch]);
      cyc++;
    end
  endtask

  initial begin
    #(40 * 20000);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    n = $urandom(32'hD6F6);
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(boost_led_mode_o === 1'b1, "boost not in LED mode after reset");
    bus(1, 'h34, 32'hFFFF_FFFF);
    foreach (ref_q[i]) ref_q.delete(i);
    for (int a = 0; a <= 'h34; a += 'h34 / 13) begin
      bus(0, a, '0);
      if (a != 'h30) chk(q === 32'h0, "register not zero after reset");
    end
    bus(1, 'h08, 32'h0);
    bus(1, 'h00, 32'h1);
    for (int i = 0; i < 6; i++) ref_q.push_back(i == 0 ? 63 : i == 1 ? 0 : $urandom_range(1, 62));
    while (ref_q.size() > 0) begin
      c = ref_q.pop_front();
      bus(1, 'h04, 32'(c));
      repeat (4) @(negedge clk_i);
      chk(sink_code_o[0] === 6'(c), "group code wrong");
      chk(sink_ua_o[0] === 15'(sq_ua(c)), "square-law current wrong");
    end
    bus(1, 'h00, 32'h0);
    repeat (3) @(negedge clk_i);
    chk(sink_code_o[0] === 6'h00, "backlight still on");
    fi = $urandom_range(1, 7);
    fo = $urandom_range(1, 7);
    bus(1, 'h08, 32'((fo << 4) | fi));
    bus(1, 'h04, 32'd10);
    bus(1, 'h00, 32'h1);
    wait_code(0, 10, 1, n);
    exp_n = 10 * tenths(fi) * STEP;
    chk(n >= exp_n - 3 && n <= exp_n + 3, "fade-in time wrong");
    bus(1, 'h00, 32'h0);
    wait_code(0, 0, 1, n);
    exp_n = 10 * tenths(fo) * STEP;
    chk(n >= exp_n - 3 && n <= exp_n + 3, "fade-out time wrong");
    bus(1, 'h08, 32'h0F);
    bus(1, 'h04, 32'd40);
    bus(1, 'h00, 32'h3);
    repeat (100) @(negedge clk_i);
    chk(sink_code_o[0] > 6'h0 && sink_code_o[0] < 6'd40, "slow fade not in progress");
    bus(1, 'h00, 32'h3);
    repeat (5) @(negedge clk_i);
    chk(sink_code_o[0] === 6'd40, "fade skip did not jump");
    bus(1, 'h08, 32'h0);
    bus(1, 'h04, 32'h128);
    for (int i = 0; i < 4; i++) bus(1, 'h10 + 4 * i, 32'(5 + 2 * i));
    bus(1, 'h24, 32'h21);
    bus(1, 'h28, 32'h21);
    bus(1, 'h0C, 32'hF);
    n = 0;
    while (!(lit[3] | lit[4]) && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk(lit[3] === 1'b1 && lit[4] === 1'b1, "blinkers did not start together");
    chk(sink_code_o[1] === 6'd40, "joined channel not on group");
    chk(sink_code_o[2] === 6'd7, "independent channel wrong");
    wait_code(4, 0, 0, n);
    wait_code(4, 11, 0, n);
    chk(n >= 2 * BLU - 1 && n <= 2 * BLU + 1, "blink off time wrong");
    bus(1, 'h20, 32'h21);
    bus(1, 'h04, 32'h328);
    repeat (3) @(negedge clk_i);
    n = 0;
    repeat (30) begin
      @(negedge clk_i);
      if (sink_code_o[2] !== 6'd40) n++;
    end
    chk(n == 0, "joined channel blinked");
    // Code byte only: the join bits must survive the partial write
    @(posedge clk_i);
    avs_byteenable_i <= 4'h1;
    bus(1, 'h04, 32'hFFFF_FF15);
    avs_byteenable_i <= 4'hF;
    bus(0, 'h04, '0);
    chk(q === 32'h0000_0315, "byte lanes not honoured");
    bus(1, 'h24, 32'h0);
    bus(1, 'h28, 32'h0);
    bus(1, 'h00, 32'h08);
    repeat (4) @(negedge clk_i);
    chk(boost_active_o === 1'b0, "boost biased independents");
    bus(1, 'h00, 32'h00);
    repeat (4) @(negedge clk_i);
    chk(boost_active_o === 1'b1, "boost ignores independents");
    bus(1, 'h00, 32'h18);
    repeat (4) @(negedge clk_i);
    chk(ovp_low_o === 1'b1 && boost_active_o === 1'b0, "overvoltage level wrong");
    bus(1, 'h00, 32'h05);
    bus(1, 'h0C, 32'hF);
    repeat (4) @(negedge clk_i);
    chk(sink_code_o === '0 && boost_led_mode_o === 1'b0, "standalone left LEDs on");
    chk(ovp_low_o === 1'b0 && total_ua === 20'h0, "standalone outputs wrong");
    end_of_test();
  end
endmodule // tb
